// >>> verilog/rf_misc_pkg.sv
// constants for the radio control, sleep calibration and battery register bank
// assumes an 8-bit register port with 12-bit addresses on a 50 MHz clock
package rf_misc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [11:0] RECEIVE_STATUS_REG              = 12'h030;
  localparam logic [11:0] BATTERY_THRESHOLD_CONTROL       = 12'h205;
  localparam logic [11:0] FILTER_RECOVERY_BATTERY_CONTROL = 12'h206;
  localparam logic [11:0] SLEEP_CLOCK_SOURCE_CONTROL      = 12'h207;
  localparam logic [11:0] VCO_TUNING_CONTROL              = 12'h208;
  localparam logic [11:0] SLEEP_CAL_COUNT_LOW             = 12'h209;
  localparam logic [11:0] SLEEP_CAL_COUNT_MID             = 12'h20a;
  localparam logic [11:0] SLEEP_CAL_COUNT_HIGH            = 12'h20b;
  localparam logic [11:0] IRQ_STATUS                      = 12'h20c;
  localparam logic [11:0] IRQ_ENABLE                      = 12'h20d;
  localparam logic [11:0] IRQ_CLEAR                       = 12'h20e;

  // field positions
  localparam int unsigned BATTERY_LOW_FLAG_BIT    = 5;
  localparam int unsigned BATTERY_TRIP_LEVEL_LSB  = 4;
  localparam int unsigned TRANSMIT_FILTER_CTL_BIT = 7;
  localparam int unsigned FAST_WAKE_RECOVERY_BIT  = 4;
  localparam int unsigned BATTERY_MONITOR_ON_BIT  = 3;
  localparam int unsigned SLEEP_CLOCK_SOURCE_LSB  = 6;
  localparam int unsigned VCO_TUNING_BIT_POS      = 4;
  localparam int unsigned SLEEP_CAL_DONE_BIT      = 7;
  localparam int unsigned SLEEP_CAL_START_BIT     = 4;
  localparam int unsigned IRQ_CAL_DONE_BIT        = 0;
  localparam int unsigned IRQ_BATTERY_LOW_BIT     = 1;

  // writable bits; everything else is reserved and holds zero
  localparam logic [7:0] THRESHOLD_WRITE_MASK = 8'hf0;
  localparam logic [7:0] RECOVERY_WRITE_MASK  = 8'h98;
  localparam logic [7:0] SOURCE_WRITE_MASK    = 8'hc0;
  localparam logic [7:0] VCO_WRITE_MASK       = 8'h10;
  localparam logic [7:0] IRQ_WRITE_MASK       = 8'h03;

  // reset values
  localparam logic [7:0] THRESHOLD_RESET  = 8'h00;
  localparam logic [7:0] RECOVERY_RESET   = 8'h00;
  localparam logic [7:0] SOURCE_RESET     = 8'h00;
  localparam logic [7:0] VCO_RESET        = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;

  // sleep clock source codes
  localparam logic [1:0] SOURCE_INTERNAL_100K = 2'b10;
  localparam logic [1:0] SOURCE_CRYSTAL_32K   = 2'b01;

  // timing
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned CAL_TICK_NS       = 50;
  localparam int unsigned CAL_PERIODS       = 16;
  localparam int unsigned CAL_COUNT_W       = 20;
  localparam int unsigned FAST_WAKE_MS      = 1;
  localparam int unsigned SLOW_WAKE_MS      = 3;
  localparam int unsigned FAST_WAKE_CYCLES  = FAST_WAKE_MS * 1000 * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLOW_WAKE_CYCLES  = SLOW_WAKE_MS * 1000 * 1000 / CLK_PERIOD_NS;

  // threshold code to trip level in millivolts, zero for undefined codes
  function automatic logic [11:0] trip_level_mv(input logic [3:0] code);
    logic [11:0] mv;
    mv = 12'h000;
    unique case (code)
      4'he: mv = 12'hdac;
      4'hd: mv = 12'hce4;
      4'hc: mv = 12'hc80;
      4'hb: mv = 12'hc1c;
      4'ha: mv = 12'haf0;
      4'h9: mv = 12'ha8c;
      4'h8: mv = 12'ha28;
      4'h7: mv = 12'h9c4;
      default: mv = 12'h000;
    endcase
    return mv;
  endfunction

endpackage

// >>> verilog/battery_monitor.sv
// battery low-voltage qualification behind an analog comparator
// assumes below_trip_in is already synchronised to clk_in
`timescale 1ns/1ns
module battery_monitor (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        monitor_on_in,
  input  wire logic [3:0]  trip_code_in,
  input  wire logic        below_trip_in,
  output logic             low_flag_out,
  output logic [11:0]      trip_mv_out
);

  logic [11:0] next_trip_mv;
  logic        next_low_flag;

  always_comb begin
    next_trip_mv  = rf_misc_pkg::trip_level_mv(trip_code_in);
    // undefined codes give no trip level, so the flag stays quiet
    next_low_flag = monitor_on_in && (next_trip_mv != 12'h000) && below_trip_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trip_mv_out  <= 12'h000;
      low_flag_out <= 1'b0;
    end else begin
      trip_mv_out  <= next_trip_mv;
      low_flag_out <= next_low_flag;
    end
  end

endmodule

// >>> verilog/sleep_cal_counter.sv
// sleep clock calibration: counts 50 ns ticks across a number of sleep periods
// assumes sleep_edge_in is a one-cycle pulse per sleep clock period on clk_in
`timescale 1ns/1ns
module sleep_cal_counter #(
  parameter int unsigned COUNT_W = rf_misc_pkg::CAL_COUNT_W,
  parameter int unsigned PERIODS = rf_misc_pkg::CAL_PERIODS
) (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               start_in,
  input  wire logic               sleep_edge_in,
  output logic [COUNT_W-1:0]      count_out,
  output logic                    done_out,
  output logic                    done_pulse_out
);

  typedef enum logic [1:0] {IDLE, ARM, MEASURE} cal_state_t;

  localparam logic [5:0] STEP = 6'(rf_misc_pkg::CLK_PERIOD_NS);
  localparam logic [5:0] WRAP = 6'(rf_misc_pkg::CAL_TICK_NS);

  cal_state_t         state, next_state;
  logic [5:0]         phase, next_phase;
  logic [COUNT_W-1:0] run, next_run, next_count;
  logic [4:0]         periods, next_periods;
  logic               next_done, next_done_pulse, tick;

  always_comb begin
    next_state      = state;
    next_phase      = phase + STEP;
    next_run        = run;
    next_periods    = periods;
    next_count      = count_out;
    next_done       = done_out;
    next_done_pulse = 1'b0;
    // 50 ns ticks from a 20 ns clock: exact on average, jitter of one clock
    tick            = (next_phase >= WRAP);
    if (tick) next_phase = next_phase - WRAP;
    if (start_in) begin
      next_state   = ARM;
      next_done    = 1'b0;
      next_run     = '0;
      next_periods = 5'h00;
      next_phase   = 6'h00;
    end else begin
      unique case (state)
        IDLE: next_phase = 6'h00;
        ARM: begin
          next_phase = 6'h00;
          if (sleep_edge_in) next_state = MEASURE;
        end
        MEASURE: begin
          if (tick && (run != '1)) next_run = run + 1'b1;
          if (sleep_edge_in) begin
            next_periods = periods + 5'h01;
            if (periods == 5'(PERIODS - 1)) begin
              next_state      = IDLE;
              next_count      = next_run;
              next_done       = 1'b1;
              next_done_pulse = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state          <= IDLE;
      phase          <= 6'h00;
      run            <= '0;
      periods        <= 5'h00;
      count_out      <= '0;
      done_out       <= 1'b0;
      done_pulse_out <= 1'b0;
    end else begin
      state          <= next_state;
      phase          <= next_phase;
      run            <= next_run;
      periods        <= next_periods;
      count_out      <= next_count;
      done_out       <= next_done;
      done_pulse_out <= next_done_pulse;
    end
  end

endmodule

// >>> verilog/rf_misc_regs.sv
// radio miscellaneous control register bank with sleep calibration and battery monitor
// assumes a same-clock register master; sleep oscillators, comparator, wake request are async
//
// Function
// - threshold codes 1110..0111 pick 3.5 V..2.5 V; lower codes are undefined
// - battery low indication reads as bit 5 of receive status at 0x30
// - monitor runs only when bit 3 of 0x206 is set; resets to 0
// - fast wake bit set gives 1 ms recovery, clear gives 3 ms; resets clear
// - bits 7:6 of 0x207 pick source: 10 internal 100 kHz, 01 crystal 32 kHz
// - 20-bit count of 16 sleep periods in 50 ns ticks
// - count is read-only, resets zero, bits 7:0 at 0x209, 15:8 at 0x20A
// - measured period follows both source choice and 5-bit divisor
// - writing 1 to bit 4 of 0x20B starts calibration; bit self-clears
// - ready flag bit 7 of 0x20B on completion; count 19:16 in bits 3:0
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module rf_misc_regs #(
  parameter int unsigned FAST_WAKE_CYCLES = rf_misc_pkg::FAST_WAKE_CYCLES,
  parameter int unsigned SLOW_WAKE_CYCLES = rf_misc_pkg::SLOW_WAKE_CYCLES
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [11:0] ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  output logic             IRQ_OUT,
  input  wire logic        SLEEP_OSC_100K_IN,
  input  wire logic        SLEEP_XTAL_32K_IN,
  input  wire logic [4:0]  SLEEP_CLOCK_DIVISOR_IN,
  input  wire logic        SUPPLY_BELOW_TRIP_IN,
  input  wire logic        WAKE_REQ_IN,
  output logic      [11:0] BATTERY_TRIP_MV_OUT,
  output logic             BATTERY_MONITOR_ON_OUT,
  output logic             TRANSMIT_FILTER_CTL_OUT,
  output logic             VCO_TUNING_BIT_OUT,
  output logic      [1:0]  SLEEP_CLOCK_SOURCE_OUT,
  output logic             REF_CLOCK_READY_OUT
);

  localparam int unsigned WAKE_W = $clog2(SLOW_WAKE_CYCLES + 1);

  // reset release
  logic rst_meta, rst_n;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // two-stage synchronisers for the four async inputs
  logic [3:0] sync_meta, sync_q;

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= 4'h0;
      sync_q    <= 4'h0;
    end else begin
      sync_meta <= {WAKE_REQ_IN, SUPPLY_BELOW_TRIP_IN, SLEEP_XTAL_32K_IN, SLEEP_OSC_100K_IN};
      sync_q    <= sync_meta;
    end
  end

  // register file
  logic [7:0] threshold, recovery, source, vco, irq_status, irq_enable;
  logic [7:0] next_threshold, next_recovery, next_source, next_vco;
  logic [7:0] next_irq_status, next_irq_enable, next_rdata;
  logic       next_irq, wr_hit_cal, battery_low, battery_low_seen;
  logic       cal_done, cal_done_pulse;
  logic [19:0] cal_count;
  logic [11:0] trip_mv;

  function automatic logic wr_at(input logic [11:0] a);
    return WR_IN && (ADDR_IN == a);
  endfunction

  always_comb begin
    next_threshold  = threshold;
    next_recovery   = recovery;
    next_source     = source;
    next_vco        = vco;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    // reserved positions are masked off on write and never become nonzero
    if (wr_at(rf_misc_pkg::BATTERY_THRESHOLD_CONTROL))
      next_threshold = WDATA_IN & rf_misc_pkg::THRESHOLD_WRITE_MASK;
    if (wr_at(rf_misc_pkg::FILTER_RECOVERY_BATTERY_CONTROL))
      next_recovery = WDATA_IN & rf_misc_pkg::RECOVERY_WRITE_MASK;
    if (wr_at(rf_misc_pkg::SLEEP_CLOCK_SOURCE_CONTROL))
      next_source = WDATA_IN & rf_misc_pkg::SOURCE_WRITE_MASK;
    if (wr_at(rf_misc_pkg::VCO_TUNING_CONTROL))
      next_vco = WDATA_IN & rf_misc_pkg::VCO_WRITE_MASK;
    if (wr_at(rf_misc_pkg::IRQ_ENABLE))
      next_irq_enable = WDATA_IN & rf_misc_pkg::IRQ_WRITE_MASK;
    if (wr_at(rf_misc_pkg::IRQ_CLEAR))
      next_irq_status = irq_status & ~WDATA_IN;
    // set after clear so an event in the clearing cycle survives
    if (cal_done_pulse)
      next_irq_status[rf_misc_pkg::IRQ_CAL_DONE_BIT] = 1'b1;
    if (battery_low && !battery_low_seen)
      next_irq_status[rf_misc_pkg::IRQ_BATTERY_LOW_BIT] = 1'b1;
    next_irq = |(next_irq_status & next_irq_enable);
    // start bit is write-only: a write pulse, never stored
    wr_hit_cal = wr_at(rf_misc_pkg::SLEEP_CAL_COUNT_HIGH)
                 && WDATA_IN[rf_misc_pkg::SLEEP_CAL_START_BIT];
  end

  always_comb begin
    next_rdata = 8'h00;
    if (RD_IN) begin
      unique case (ADDR_IN)
        rf_misc_pkg::RECEIVE_STATUS_REG:
          next_rdata[rf_misc_pkg::BATTERY_LOW_FLAG_BIT] = battery_low;
        rf_misc_pkg::BATTERY_THRESHOLD_CONTROL:       next_rdata = threshold;
        rf_misc_pkg::FILTER_RECOVERY_BATTERY_CONTROL: next_rdata = recovery;
        rf_misc_pkg::SLEEP_CLOCK_SOURCE_CONTROL:      next_rdata = source;
        rf_misc_pkg::VCO_TUNING_CONTROL:              next_rdata = vco;
        rf_misc_pkg::SLEEP_CAL_COUNT_LOW:             next_rdata = cal_count[7:0];
        rf_misc_pkg::SLEEP_CAL_COUNT_MID:             next_rdata = cal_count[15:8];
        rf_misc_pkg::SLEEP_CAL_COUNT_HIGH: begin
          next_rdata[3:0] = cal_count[19:16];
          next_rdata[rf_misc_pkg::SLEEP_CAL_DONE_BIT] = cal_done;
        end
        rf_misc_pkg::IRQ_STATUS: next_rdata = irq_status;
        rf_misc_pkg::IRQ_ENABLE: next_rdata = irq_enable;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      threshold        <= rf_misc_pkg::THRESHOLD_RESET;
      recovery         <= rf_misc_pkg::RECOVERY_RESET;
      source           <= rf_misc_pkg::SOURCE_RESET;
      vco              <= rf_misc_pkg::VCO_RESET;
      irq_enable       <= rf_misc_pkg::IRQ_ENABLE_RESET;
      irq_status       <= 8'h00;
      battery_low_seen <= 1'b0;
      RDATA_OUT        <= 8'h00;
      IRQ_OUT          <= 1'b0;
    end else begin
      threshold        <= next_threshold;
      recovery         <= next_recovery;
      source           <= next_source;
      vco              <= next_vco;
      irq_enable       <= next_irq_enable;
      irq_status       <= next_irq_status;
      battery_low_seen <= battery_low;
      RDATA_OUT        <= next_rdata;
      IRQ_OUT          <= next_irq;
    end
  end

  // control outputs, one flop behind the registers; trip level two flops behind threshold
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      BATTERY_MONITOR_ON_OUT  <= 1'b0;
      TRANSMIT_FILTER_CTL_OUT <= 1'b0;
      VCO_TUNING_BIT_OUT      <= 1'b0;
      SLEEP_CLOCK_SOURCE_OUT  <= 2'b00;
      BATTERY_TRIP_MV_OUT     <= 12'h000;
    end else begin
      BATTERY_MONITOR_ON_OUT  <= recovery[rf_misc_pkg::BATTERY_MONITOR_ON_BIT];
      TRANSMIT_FILTER_CTL_OUT <= recovery[rf_misc_pkg::TRANSMIT_FILTER_CTL_BIT];
      VCO_TUNING_BIT_OUT      <= vco[rf_misc_pkg::VCO_TUNING_BIT_POS];
      SLEEP_CLOCK_SOURCE_OUT  <= source[rf_misc_pkg::SLEEP_CLOCK_SOURCE_LSB +: 2];
      BATTERY_TRIP_MV_OUT     <= trip_mv;
    end
  end

  // sleep clock: selected oscillator divided by the divisor field
  logic       src_level, src_last, src_rise, sleep_edge, next_sleep_edge;
  logic [4:0] div_cnt, next_div_cnt, div_top;

  always_comb begin
    unique case (source[rf_misc_pkg::SLEEP_CLOCK_SOURCE_LSB +: 2])
      rf_misc_pkg::SOURCE_INTERNAL_100K: src_level = sync_q[0];
      rf_misc_pkg::SOURCE_CRYSTAL_32K:   src_level = sync_q[1];
      default:                           src_level = 1'b0;
    endcase
    src_rise        = src_level && !src_last;
    // divisor 0 behaves as 1 so the sleep clock never stops
    div_top         = (SLEEP_CLOCK_DIVISOR_IN == 5'h00) ? 5'h00 : SLEEP_CLOCK_DIVISOR_IN - 5'h01;
    next_div_cnt    = div_cnt;
    next_sleep_edge = 1'b0;
    if (src_rise) begin
      if (div_cnt >= div_top) begin
        next_div_cnt    = 5'h00;
        next_sleep_edge = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      src_last   <= 1'b0;
      div_cnt    <= 5'h00;
      sleep_edge <= 1'b0;
    end else begin
      src_last   <= src_level;
      div_cnt    <= next_div_cnt;
      sleep_edge <= next_sleep_edge;
    end
  end

  sleep_cal_counter #(
    .COUNT_W (rf_misc_pkg::CAL_COUNT_W),
    .PERIODS (rf_misc_pkg::CAL_PERIODS)
  ) u_cal (
    .clk_in         (MCLK_IN),
    .rst_n_in       (rst_n),
    .start_in       (wr_hit_cal),
    .sleep_edge_in  (sleep_edge),
    .count_out      (cal_count),
    .done_out       (cal_done),
    .done_pulse_out (cal_done_pulse)
  );

  battery_monitor u_battery (
    .clk_in        (MCLK_IN),
    .rst_n_in      (rst_n),
    .monitor_on_in (recovery[rf_misc_pkg::BATTERY_MONITOR_ON_BIT]),
    .trip_code_in  (threshold[rf_misc_pkg::BATTERY_TRIP_LEVEL_LSB +: 4]),
    .below_trip_in (sync_q[2]),
    .low_flag_out  (battery_low),
    .trip_mv_out   (trip_mv)
  );

  // reference clock recovery after a wake request
  logic              wake_last, next_ready;
  logic [WAKE_W-1:0] wake_cnt, next_wake_cnt;

  always_comb begin
    next_wake_cnt = wake_cnt;
    next_ready    = REF_CLOCK_READY_OUT;
    if (sync_q[3] && !wake_last) begin
      next_ready    = 1'b0;
      next_wake_cnt = recovery[rf_misc_pkg::FAST_WAKE_RECOVERY_BIT]
                      ? WAKE_W'(FAST_WAKE_CYCLES - 1)
                      : WAKE_W'(SLOW_WAKE_CYCLES - 1);
    end else if (!REF_CLOCK_READY_OUT) begin
      if (wake_cnt == '0) next_ready = 1'b1;
      else next_wake_cnt = wake_cnt - 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wake_last           <= 1'b0;
      wake_cnt            <= '0;
      REF_CLOCK_READY_OUT <= 1'b1;
    end else begin
      wake_last           <= sync_q[3];
      wake_cnt            <= next_wake_cnt;
      REF_CLOCK_READY_OUT <= next_ready;
    end
  end

endmodule

// >>> tb/rf_misc_regs_props.sv
// assertions for the radio misc register bank, watching its top ports only
// assumes one clock domain; bound to every rf_misc_regs instance below
`timescale 1ns/1ns
module rf_misc_regs_props #(
  parameter int unsigned FAST_WAKE_CYCLES = 5,
  parameter int unsigned SLOW_WAKE_CYCLES = 15
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [11:0] ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  input  wire logic [7:0]  RDATA_OUT,
  input  wire logic [11:0] BATTERY_TRIP_MV_OUT,
  input  wire logic        BATTERY_MONITOR_ON_OUT,
  input  wire logic        TRANSMIT_FILTER_CTL_OUT,
  input  wire logic        VCO_TUNING_BIT_OUT,
  input  wire logic [1:0]  SLEEP_CLOCK_SOURCE_OUT,
  input  wire logic        REF_CLOCK_READY_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [31:0] low_run;
  logic [31:0] next_low_run;
  always_comb begin
    next_low_run = REF_CLOCK_READY_OUT ? 32'h0 : low_run + 32'h1;
  end
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      low_run <= 32'h0;
    end else begin
      low_run <= next_low_run;
    end
  end
  property p_filter_follow;
    WR_IN && ADDR_IN == 12'h206 |-> ##2 TRANSMIT_FILTER_CTL_OUT == $past(WDATA_IN[7], 2);
  endproperty
  a_filter_follow: assert property (p_filter_follow)
    else $error("filter output does not follow its bit");
  property p_monitor_follow;
    WR_IN && ADDR_IN == 12'h206 |-> ##2 BATTERY_MONITOR_ON_OUT == $past(WDATA_IN[3], 2);
  endproperty
  a_monitor_follow: assert property (p_monitor_follow)
    else $error("monitor enable output does not follow its bit");
  property p_vco_follow;
    WR_IN && ADDR_IN == 12'h208 |-> ##2 VCO_TUNING_BIT_OUT == $past(WDATA_IN[4], 2);
  endproperty
  a_vco_follow: assert property (p_vco_follow)
    else $error("vco output does not follow its bit");
  property p_source_follow;
    WR_IN && ADDR_IN == 12'h207 |-> ##2 SLEEP_CLOCK_SOURCE_OUT == $past(WDATA_IN[7:6], 2);
  endproperty
  a_source_follow: assert property (p_source_follow)
    else $error("sleep source output does not follow its field");
  property p_trip_legal;
    BATTERY_TRIP_MV_OUT inside {12'd0, 12'd2500, 12'd2600, 12'd2700, 12'd2800, 12'd3100,
                                12'd3200, 12'd3300, 12'd3500};
  endproperty
  a_trip_legal: assert property (p_trip_legal)
    else $error("trip level outside the coded set");
  property p_batt_quiet;
    RD_IN && ADDR_IN == 12'h030 && (BATTERY_TRIP_MV_OUT == 12'd0 ||
      (!BATTERY_MONITOR_ON_OUT && !$past(BATTERY_MONITOR_ON_OUT))) |=> !RDATA_OUT[5];
  endproperty
  a_batt_quiet: assert property (p_batt_quiet)
    else $error("low flag set while monitor off or code undefined");
  property p_cal_reserved;
    RD_IN && ADDR_IN == 12'h20b |=> RDATA_OUT[6:4] == 3'b000;
  endproperty
  a_cal_reserved: assert property (p_cal_reserved)
    else $error("start or reserved bits read nonzero");
  property p_vco_reserved;
    RD_IN && ADDR_IN == 12'h208 |=> (RDATA_OUT & 8'hef) == 8'h00;
  endproperty
  a_vco_reserved: assert property (p_vco_reserved)
    else $error("reserved vco register bits read nonzero");
  property p_wake_short;
    $rose(REF_CLOCK_READY_OUT) |-> low_run + 32'd1 >= FAST_WAKE_CYCLES;
  endproperty
  a_wake_short: assert property (p_wake_short)
    else $error("clock recovery shorter than fast setting");
  property p_wake_long;
    !REF_CLOCK_READY_OUT |-> low_run <= SLOW_WAKE_CYCLES + 1;
  endproperty
  a_wake_long: assert property (p_wake_long)
    else $error("clock recovery longer than slow setting");
  c_cal_start: cover property (WR_IN && ADDR_IN == 12'h20b && WDATA_IN[4]);
  c_wake_done: cover property ($rose(REF_CLOCK_READY_OUT));
  c_batt_low: cover property (RD_IN && ADDR_IN == 12'h030 ##1 RDATA_OUT[5]);
endmodule

bind rf_misc_regs rf_misc_regs_props #(
  .FAST_WAKE_CYCLES(FAST_WAKE_CYCLES), .SLOW_WAKE_CYCLES(SLOW_WAKE_CYCLES)
) props (
  .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .BATTERY_TRIP_MV_OUT(BATTERY_TRIP_MV_OUT), .BATTERY_MONITOR_ON_OUT(BATTERY_MONITOR_ON_OUT),
  .TRANSMIT_FILTER_CTL_OUT(TRANSMIT_FILTER_CTL_OUT), .VCO_TUNING_BIT_OUT(VCO_TUNING_BIT_OUT),
  .SLEEP_CLOCK_SOURCE_OUT(SLEEP_CLOCK_SOURCE_OUT), .REF_CLOCK_READY_OUT(REF_CLOCK_READY_OUT)
);

// >>> tb/rf_misc_regs_tb.sv
// self-checking bench for the radio misc register bank
// assumes short wake counts (5 and 15) and sleep clocks made from the 50 MHz clock
`timescale 1ns/1ns
module rf_misc_regs_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        osc = 1'b0;
  logic        xtal = 1'b0;
  logic        below = 1'b0;
  logic        wake = 1'b0;
  logic [4:0]  div = 5'h01;
  logic [9:0]  c100 = 10'h000;
  logic [9:0]  cx = 10'h000;
  logic [7:0]  rdata;
  logic        irq;
  logic [11:0] trip_mv;
  logic        mon;
  logic        filt;
  logic        vco;
  logic [1:0]  src;
  logic        ready;
  int          bad_count = 0;
  int          samples_checked = 0;

  rf_misc_regs #(.FAST_WAKE_CYCLES(5), .SLOW_WAKE_CYCLES(15)) dut (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_en),
    .RD_IN(rd_en), .RDATA_OUT(rdata), .IRQ_OUT(irq), .SLEEP_OSC_100K_IN(osc),
    .SLEEP_XTAL_32K_IN(xtal), .SLEEP_CLOCK_DIVISOR_IN(div), .SUPPLY_BELOW_TRIP_IN(below),
    .WAKE_REQ_IN(wake), .BATTERY_TRIP_MV_OUT(trip_mv), .BATTERY_MONITOR_ON_OUT(mon),
    .TRANSMIT_FILTER_CTL_OUT(filt), .VCO_TUNING_BIT_OUT(vco), .SLEEP_CLOCK_SOURCE_OUT(src),
    .REF_CLOCK_READY_OUT(ready)
  );

  always #10 clk = ~clk;
  // 100 kHz: 250-cycle half period; crystal: 763-cycle half period (15260 ns)
  always @(posedge clk) begin
    c100 <= (c100 == 10'd249) ? 10'd0 : c100 + 10'd1;
    cx <= (cx == 10'd762) ? 10'd0 : cx + 10'd1;
    if (c100 == 10'd249) osc <= ~osc;
    if (cx == 10'd762) xtal <= ~xtal;
  end

  task automatic results();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // measured values carry up to a two-tick phase uncertainty
  function automatic logic [19:0] near(input logic [19:0] exp, input logic [19:0] got);
    return (got + 20'd2 >= exp && got <= exp + 20'd2) ? exp : got;
  endfunction
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    chk($sformatf("reg %h", a), {12'h000, exp}, {12'h000, d});
  endtask
  function automatic logic [11:0] exp_mv(input int c);
    case (c)
      14: return 12'd3500;
      13: return 12'd3300;
      12: return 12'd3200;
      11: return 12'd3100;
      10: return 12'd2800;
      9: return 12'd2700;
      8: return 12'd2600;
      7: return 12'd2500;
      default: return 12'd0;
    endcase
  endfunction

  task automatic check_reset();
    for (int a = 12'h205; a <= 12'h20d; a++) chk_rd(a[11:0], 8'h00);
    chk_rd(12'h030, 8'h00);
    chk("ctl outs", 20'h0, {14'h0, mon, filt, vco, src, irq});
  endtask
  task automatic check_masks();
    logic [7:0] msk [4];
    msk = '{8'hf0, 8'h98, 8'hc0, 8'h10};
    for (int i = 0; i < 4; i++) reg_write(12'h205 + 12'(i), 8'hff);
    for (int i = 0; i < 4; i++) chk_rd(12'h205 + 12'(i), msk[i]);
    chk("ctl set", 20'h1f, {15'h0, mon, filt, vco, src});
    chk("undef trip", 20'h0, {8'h0, trip_mv});
    reg_write(12'h209, 8'hff);
    reg_write(12'h20a, 8'hff);
    chk_rd(12'h209, 8'h00);
    chk_rd(12'h20a, 8'h00);
    chk_rd(12'h2ff, 8'h00);
    for (int i = 0; i < 4; i++) reg_write(12'h205 + 12'(i), 8'h00);
  endtask
  task automatic check_battery();
    below <= 1'b1;
    reg_write(12'h206, 8'h08);
    for (int c = 0; c < 16; c++) begin
      reg_write(12'h205, {c[3:0], 4'h0});
      repeat (4) @(posedge clk);
      #1;
      chk("trip mv", {8'h0, exp_mv(c)}, {8'h0, trip_mv});
      chk_rd(12'h030, (c >= 7 && c <= 14) ? 8'h20 : 8'h00);
    end
    reg_write(12'h205, 8'he0);
    reg_write(12'h206, 8'h00);
    repeat (5) @(posedge clk);
    chk_rd(12'h030, 8'h00);
    chk_rd(12'h20c, 8'h02);
    reg_write(12'h20d, 8'h02);
    repeat (3) @(posedge clk);
    chk("irq on", 20'h1, {19'h0, irq});
    below <= 1'b0;
    reg_write(12'h20e, 8'h02);
    repeat (3) @(posedge clk);
    chk("irq off", 20'h0, {19'h0, irq});
    reg_write(12'h20d, 8'h01);
  endtask
  task automatic cal_run(input logic [1:0] s, input logic [4:0] dv, input logic [19:0] exp);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    int n;
    reg_write(12'h207, {s, 6'h00});
    div <= dv;
    reg_write(12'h20b, 8'h10);
    chk_rd(12'h20b, 8'h00);
    b2 = 8'h00;
    for (n = 0; n < 20000 && b2[7] !== 1'b1; n++) reg_read(12'h20b, b2);
    chk("cal ready", 20'h1, {19'h0, b2[7]});
    if (b2[7] !== 1'b1) results();
    repeat (3) @(posedge clk);
    chk("cal irq", 20'h1, {19'h0, irq});
    reg_read(12'h209, b0);
    reg_read(12'h20a, b1);
    chk("cal count", exp, near(exp, {b2[3:0], b1, b0}));
    repeat (600) @(posedge clk);
    chk_rd(12'h209, b0);
    reg_write(12'h20e, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq clear", 20'h0, {19'h0, irq});
  endtask
  task automatic wake_run(input logic fast, input logic [19:0] exp);
    logic [19:0] lows;
    int k;
    reg_write(12'h206, {3'b000, fast, 4'h0});
    wake <= 1'b1;
    for (k = 0; k < 20 && ready !== 1'b0; k++) @(posedge clk) #1;
    for (lows = 20'h0; lows < 20'd40 && ready === 1'b0; lows++) @(posedge clk) #1;
    chk("wake low", exp, lows);
    @(posedge clk);
    wake <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    chk("reset ready", 20'h1, {19'h0, ready});
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check_reset();
    check_masks();
    check_battery();
    cal_run(2'b10, 5'h01, 20'd3200);
    cal_run(2'b10, 5'h02, 20'd6400);
    cal_run(2'b01, 5'h01, 20'd9766);
    wake_run(1'b1, 20'd5);
    wake_run(1'b0, 20'd15);
    results();
  end
endmodule
